// *** verilog/xdr_rx_top.sv ***
/*
  Receive deskew, channel alignment and rate-match elastic buffer for a
  four-lane link, with a small register port and one interrupt.
  Assumes word-aligned lanes, lane_valid common to all lanes, one clock.
*/
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module xdr_rx_top
  import xdr_pkg::*;
#(
  parameter int DSK_D = DSK_DEPTH,
  parameter int EB_D = EB_DEPTH,
  parameter int EB_HI = EB_HI_MARK,
  parameter int EB_LO = EB_LO_MARK
)
(
  input logic clk,
  input logic rst_n,
  input logic receive_logic_reset,
  input logic [3:0] lane_sync_in,
  input logic lane_valid,
  input logic [31:0] lane_data,
  input logic [3:0] lane_kflag,
  input logic fabric_ready,
  input logic [4:0] bus_addr,
  input logic [31:0] bus_wdata,
  input logic bus_wr,
  input logic bus_rd,
  output logic [3:0] lane_sync_ok,
  output logic lanes_aligned,
  output logic [31:0] rx_data,
  output logic [3:0] rx_kflag,
  output logic rx_valid,
  output logic [3:0] column_dropped_pulse,
  output logic [3:0] column_added_pulse,
  output logic elastic_full_flag,
  output logic elastic_empty_flag,
  output logic [31:0] bus_rdata,
  output logic irq
);
  localparam int EAW = $clog2(EB_D);

  logic [3:0] sync_r, sync_nxt;
  logic all_sync;
  xdr_dsk_t ds_r, ds_nxt;
  logic [3:0] start_r, start_nxt, win_r, win_nxt;
  logic [3:0] a_in, a_out, r_in, r_head, dsk_wr;
  logic dsk_rd, dsk_clr, realign, col_aln, col_mis;
  logic [COL_W-1:0] dsk_col, col_r, col_nxt, head;
  logic col_v_r, col_v_nxt;
  xdr_aln_t al_r, al_nxt;
  logic [2:0] acq_r, acq_nxt, miss_r, miss_nxt;
  logic aligned_r, aligned_nxt;

  logic [COL_W-1:0] eb_mem_r [EB_D];
  logic [EAW:0] eb_wp_r, eb_wp_nxt, eb_rp_r, eb_rp_nxt, fill;
  logic eb_we, rm_on, drop_now, add_now, full_ev, empty_ev;
  logic [31:0] head_d, rx_data_r, rx_data_nxt;
  logic [3:0] head_k, rx_kflag_r, rx_kflag_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic [1:0] full_cnt_r, full_cnt_nxt, empty_cnt_r, empty_cnt_nxt;
  logic [3:0] drop_p_r, drop_p_nxt, add_p_r, add_p_nxt;
  logic full_flag_r, full_flag_nxt, empty_flag_r, empty_flag_nxt;

  logic [NUM_EV-1:0] status_r, status_nxt, en_r, en_nxt, ev, clr_mask;
  logic ctrl_r, ctrl_nxt, irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  assign all_sync = &sync_r;
  assign col_aln = col_v_r && (&a_out);
  assign col_mis = col_v_r && (|a_out) && !(&a_out);
  assign fill = eb_wp_r - eb_rp_r;
  assign head = eb_mem_r[eb_rp_r[EAW-1:0]];
  assign rm_on = all_sync && aligned_r && ctrl_r;

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      xdr_lane_if lif();
      assign a_in[g] = lane_valid && lane_kflag[g]
        && lane_data[8*g +: 8] == CODE_ALIGN;
      assign a_out[g] = col_r[LANE_W*g+8]
        && col_r[LANE_W*g +: 8] == CODE_ALIGN;
      assign r_in[g] = col_r[LANE_W*g+8]
        && col_r[LANE_W*g +: 8] == CODE_IDLE_R;
      assign head_d[8*g +: 8] = head[LANE_W*g +: 8];
      assign head_k[g] = head[LANE_W*g+8];
      assign r_head[g] = head_k[g] && head_d[8*g +: 8] == CODE_IDLE_R;
      assign lif.clr = dsk_clr;
      assign lif.wr = dsk_wr[g];
      assign lif.rd = dsk_rd;
      assign lif.din = {lane_kflag[g], lane_data[8*g +: 8]};
      assign dsk_col[LANE_W*g +: LANE_W] = lif.dout;
      xdr_dsk_fifo #(.DEPTH(DSK_D)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .lf(lif.fifo)
      );
    end
  endgenerate

  // sync, channel alignment and deskew
  always_comb
  begin
    sync_nxt = receive_logic_reset ? 4'h0 : lane_sync_in;
    al_nxt = al_r;
    acq_nxt = acq_r;
    miss_nxt = miss_r;
    realign = 1'b0;
    if (receive_logic_reset || ds_r != DS_RUN || !all_sync)
    begin
      al_nxt = AL_ACQ;
      acq_nxt = '0;
      miss_nxt = '0;
    end
    else
    begin
      unique case (al_r)
        AL_ACQ:
          if (col_mis)
          begin
            acq_nxt = '0;
            realign = 1'b1;
          end
          else if (col_aln)
          begin
            if (acq_r == 3'(ACQ_EXTRA))
              al_nxt = AL_OK;
            else
              acq_nxt = acq_r + 1'b1;
          end
        AL_OK:
          if (col_aln)
            miss_nxt = '0;
          else if (col_mis)
          begin
            if (miss_r == 3'(LOSS_MISS - 1))
            begin
              al_nxt = AL_ACQ;
              miss_nxt = '0;
              acq_nxt = '0;
              realign = 1'b1;
            end
            else
              miss_nxt = miss_r + 1'b1;
          end
      endcase
    end
    aligned_nxt = (al_nxt == AL_OK);

    ds_nxt = ds_r;
    start_nxt = start_r;
    win_nxt = win_r;
    dsk_clr = 1'b0;
    if (receive_logic_reset || !all_sync || realign)
      dsk_clr = 1'b1;
    else
    begin
      unique case (ds_r)
        DS_IDLE:
        begin
          start_nxt = a_in;
          if (&a_in)
            ds_nxt = DS_RUN;
          else if (|a_in)
            ds_nxt = DS_FILL;
        end
        DS_FILL:
        begin
          start_nxt = start_r | a_in;
          win_nxt = win_r + 1'b1;
          if (&start_nxt)
            ds_nxt = DS_RUN;
          else if (win_nxt == 4'(DESKEW_WIN - 1))
            dsk_clr = 1'b1;
        end
        DS_RUN:
          win_nxt = win_r;
      endcase
    end
    if (dsk_clr)
    begin
      ds_nxt = DS_IDLE;
      start_nxt = '0;
      win_nxt = '0;
    end
    // lanes past their A keep writing; read stays frozen until release
    dsk_wr = (ds_r == DS_RUN) ? {4{lane_valid}} : (start_r | a_in);
    dsk_wr = dsk_clr ? 4'h0 : dsk_wr;
    dsk_rd = (ds_r == DS_RUN) && lane_valid && !dsk_clr;
    col_v_nxt = dsk_rd;
    col_nxt = dsk_col;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_r <= '0;
      al_r <= AL_ACQ;
      acq_r <= '0;
      miss_r <= '0;
      aligned_r <= 1'b0;
      ds_r <= DS_IDLE;
      start_r <= '0;
      win_r <= '0;
      col_v_r <= 1'b0;
      col_r <= '0;
    end
    else
    begin
      sync_r <= sync_nxt;
      al_r <= al_nxt;
      acq_r <= acq_nxt;
      miss_r <= miss_nxt;
      aligned_r <= aligned_nxt;
      ds_r <= ds_nxt;
      start_r <= start_nxt;
      win_r <= win_nxt;
      col_v_r <= col_v_nxt;
      col_r <= col_nxt;
    end
  end

  // rate match: only whole columns move, so lanes never slip apart
  always_comb
  begin
    eb_wp_nxt = eb_wp_r;
    eb_rp_nxt = eb_rp_r;
    eb_we = 1'b0;
    drop_now = 1'b0;
    add_now = 1'b0;
    full_ev = 1'b0;
    empty_ev = 1'b0;
    rx_data_nxt = rx_data_r;
    rx_kflag_nxt = rx_kflag_r;
    rx_valid_nxt = 1'b0;
    full_cnt_nxt = (full_cnt_r != 2'h0) ? full_cnt_r - 1'b1 : 2'h0;
    empty_cnt_nxt = (empty_cnt_r != 2'h0) ? empty_cnt_r - 1'b1 : 2'h0;
    if (receive_logic_reset)
    begin
      eb_wp_nxt = '0;
      eb_rp_nxt = '0;
      full_cnt_nxt = 2'h0;
      empty_cnt_nxt = 2'h0;
    end
    else
    begin
      if (col_v_r)
      begin
        if (rm_on && (&r_in) && fill >= (EAW+1)'(EB_HI))
          drop_now = 1'b1;
        else if (fill == (EAW+1)'(EB_D))
          full_ev = 1'b1;
        else
        begin
          eb_we = 1'b1;
          eb_wp_nxt = eb_wp_r + 1'b1;
        end
      end
      if (fabric_ready)
      begin
        if (fill == '0)
          empty_ev = rm_on;
        else
        begin
          rx_valid_nxt = 1'b1;
          rx_data_nxt = head_d;
          rx_kflag_nxt = head_k;
          if (rm_on && (&r_head) && fill <= (EAW+1)'(EB_LO))
            add_now = 1'b1;
          else
            eb_rp_nxt = eb_rp_r + 1'b1;
        end
      end
      if (full_ev)
        full_cnt_nxt = 2'(FLAG_HOLD);
      if (empty_ev)
        empty_cnt_nxt = 2'(FLAG_HOLD);
    end
    drop_p_nxt = {4{drop_now}};
    add_p_nxt = {4{add_now}};
    full_flag_nxt = full_cnt_nxt != 2'h0;
    empty_flag_nxt = empty_cnt_nxt != 2'h0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      eb_wp_r <= '0;
      eb_rp_r <= '0;
      rx_data_r <= '0;
      rx_kflag_r <= '0;
      rx_valid_r <= 1'b0;
      full_cnt_r <= '0;
      empty_cnt_r <= '0;
      drop_p_r <= '0;
      add_p_r <= '0;
      full_flag_r <= 1'b0;
      empty_flag_r <= 1'b0;
    end
    else
    begin
      eb_wp_r <= eb_wp_nxt;
      eb_rp_r <= eb_rp_nxt;
      rx_data_r <= rx_data_nxt;
      rx_kflag_r <= rx_kflag_nxt;
      rx_valid_r <= rx_valid_nxt;
      full_cnt_r <= full_cnt_nxt;
      empty_cnt_r <= empty_cnt_nxt;
      drop_p_r <= drop_p_nxt;
      add_p_r <= add_p_nxt;
      full_flag_r <= full_flag_nxt;
      empty_flag_r <= empty_flag_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (eb_we)
      eb_mem_r[eb_wp_r[EAW-1:0]] <= col_r;
  end

  // register port and interrupt; a set in the clear cycle wins
  always_comb
  begin
    ev = '0;
    ev[EV_ALIGN_UP] = aligned_nxt && !aligned_r;
    ev[EV_ALIGN_DOWN] = !aligned_nxt && aligned_r;
    ev[EV_DROP] = drop_now;
    ev[EV_ADD] = add_now;
    ev[EV_FULL] = full_ev;
    ev[EV_EMPTY] = empty_ev;
    en_nxt = en_r;
    ctrl_nxt = ctrl_r;
    clr_mask = '0;
    rdata_nxt = '0;
    if (bus_wr)
    begin
      case (bus_addr)
        ADDR_IRQ_EN: en_nxt = bus_wdata[NUM_EV-1:0];
        ADDR_IRQ_CLR: clr_mask = bus_wdata[NUM_EV-1:0];
        ADDR_CTRL: ctrl_nxt = bus_wdata[CTRL_RM_EN];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    if (bus_rd)
    begin
      case (bus_addr)
        ADDR_STATUS: rdata_nxt[NUM_EV-1:0] = status_r;
        ADDR_IRQ_EN: rdata_nxt[NUM_EV-1:0] = en_r;
        ADDR_CTRL: rdata_nxt[CTRL_RM_EN] = ctrl_r;
        ADDR_STATE:
        begin
          rdata_nxt[ST_ALIGNED] = aligned_r;
          rdata_nxt[ST_SYNC_LSB +: 4] = sync_r;
          rdata_nxt[ST_FILL_LSB +: EAW+1] = fill;
        end
        default: rdata_nxt = '0;
      endcase
    end
    status_nxt = (status_r & ~clr_mask) | ev;
    irq_nxt = |(status_nxt & en_nxt);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      status_r <= '0;
      en_r <= IRQ_EN_RST;
      ctrl_r <= CTRL_RST;
      rdata_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      en_r <= en_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign lane_sync_ok = sync_r;
  assign lanes_aligned = aligned_r;
  assign rx_data = rx_data_r;
  assign rx_kflag = rx_kflag_r;
  assign rx_valid = rx_valid_r;
  assign column_dropped_pulse = drop_p_r;
  assign column_added_pulse = add_p_r;
  assign elastic_full_flag = full_flag_r;
  assign elastic_empty_flag = empty_flag_r;
  assign bus_rdata = rdata_r;
  assign irq = irq_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_ACQ_AFTER_THREE: assert property (
    $rose(lanes_aligned) |-> $past(acq_r) == 3'(ACQ_EXTRA) && $past(col_aln))
    else $error("alignment raised without four aligned columns");
  AST_LOSS_AFTER_FOUR: assert property (
    aligned_r && col_mis && miss_r == 3'(LOSS_MISS - 1)
      && !receive_logic_reset |=> !lanes_aligned)
    else $error("alignment kept after four misaligned columns");
  AST_RM_GATED: assert property (
    (column_added_pulse != 4'h0 || column_dropped_pulse != 4'h0)
      |-> $past(rm_on))
    else $error("rate match acted before sync and alignment");
  AST_WHOLE_COLUMN: assert property (
    (drop_now |-> &r_in) and (add_now |-> &r_head))
    else $error("rate match acted on a partial idle column");
  AST_DROP_PULSE: assert property (
    drop_now |=> column_dropped_pulse == 4'hf)
    else $error("drop not flagged on all lanes");
  AST_ADD_PULSE: assert property (
    $rose(column_added_pulse[0]) |-> $past(add_now)
      && column_added_pulse == 4'hf)
    else $error("add flag without an added column");
  AST_NO_RECOVER: assert property (
    full_ev |=> eb_wp_r == $past(eb_wp_r))
    else $error("write pointer moved on overflow");
  AST_FULL_HOLD: assert property (
    disable iff (!rst_n || receive_logic_reset)
    $rose(elastic_full_flag) |-> elastic_full_flag [*3])
    else $error("full flag shorter than three cycles");
  AST_EMPTY_HOLD: assert property (
    disable iff (!rst_n || receive_logic_reset)
    $rose(elastic_empty_flag) |-> elastic_empty_flag [*3])
    else $error("empty flag shorter than three cycles");
  AST_SYNC_LOSS: assert property (
    lane_sync_in != 4'hf |=> ##1 !lanes_aligned)
    else $error("alignment kept after lane sync loss");
  AST_DSK_FROZEN: assert property (
    ds_r != DS_RUN |-> !dsk_rd && (ds_r != DS_IDLE || dsk_wr == a_in
      || dsk_clr))
    else $error("deskew pointer moved before release");
  AST_DSK_WINDOW: assert property (
    ds_r == DS_FILL && ds_nxt == DS_RUN |-> win_r < 4'(DESKEW_WIN - 1))
    else $error("deskew released outside the window");
  AST_RLR_CLEARS: assert property (
    receive_logic_reset |=> !lanes_aligned && !elastic_full_flag
      && !elastic_empty_flag && column_added_pulse == 4'h0
      && column_dropped_pulse == 4'h0 && eb_wp_r == eb_rp_r)
    else $error("receive reset left state behind");

  COV_ALIGNED: cover property ($rose(lanes_aligned));
  COV_DROP: cover property (column_dropped_pulse == 4'hf);
  COV_ADD: cover property (column_added_pulse == 4'hf);
  COV_FULL: cover property ($rose(elastic_full_flag));
endmodule // xdr_rx_top

// *** verilog/xdr_pkg.sv ***
/*
  Shared constants and types for the four-lane receive deskew and rate
  match block. Assumes 8b/10b decoded lanes carrying {k flag, byte}.
*/
// Behaviour
// - aligned only after first plus three more aligned A columns at outputs.
// - while aligned, four misaligned A columns without aligned one drop it.
// - elastic buffer absorbs up to 100 ppm each way, 200 ppm total.
// - no rate matching until all lanes synced and lanes aligned.
// - find all-lane R columns, drop or add whole columns against over/underrun.
// - each dropped R column pulses the drop flag one cycle on all lanes.
// - each added R column pulses the add flag one cycle on all lanes.
// - full or empty buffer is only reported, never repaired by the block.
// - full and empty flags stay high at least three cycles.
// - per-lane sync ok follows the aligner, cleared on loss or reset.
// - deskew pointers idle until first A; then write runs, read frozen.
// - A on all lanes within ten cycles releases all reads together.
package xdr_pkg;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int COL_W = LANES * LANE_W;
  localparam logic [7:0] CODE_ALIGN = 8'h7c;
  localparam logic [7:0] CODE_IDLE_R = 8'h1c;
  localparam int DESKEW_WIN = 10;
  localparam int ACQ_EXTRA = 3;
  localparam int LOSS_MISS = 4;
  localparam int FLAG_HOLD = 3;
  localparam int PPM_EACH = 100;
  localparam int PPM_TOTAL = 2 * PPM_EACH;
  // 200 ppm slips one column per 5000; marks leave 4 columns either side
  localparam int DSK_DEPTH = 16;
  localparam int EB_DEPTH = 16;
  localparam int EB_HI_MARK = 12;
  localparam int EB_LO_MARK = 4;
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h04;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h08;
  localparam logic [4:0] ADDR_CTRL = 5'h0c;
  localparam logic [4:0] ADDR_STATE = 5'h10;
  localparam int NUM_EV = 6;
  localparam int EV_ALIGN_UP = 0;
  localparam int EV_ALIGN_DOWN = 1;
  localparam int EV_DROP = 2;
  localparam int EV_ADD = 3;
  localparam int EV_FULL = 4;
  localparam int EV_EMPTY = 5;
  localparam int CTRL_RM_EN = 0;
  localparam logic CTRL_RST = 1'b1;
  localparam logic [NUM_EV-1:0] IRQ_EN_RST = '0;
  localparam int ST_ALIGNED = 0;
  localparam int ST_SYNC_LSB = 1;
  localparam int ST_FILL_LSB = 8;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_FILL = 3'b010,
    DS_RUN = 3'b100
  } xdr_dsk_t;
  typedef enum logic [1:0] {
    AL_ACQ = 2'b01,
    AL_OK = 2'b10
  } xdr_aln_t;
endpackage

// *** verilog/xdr_lane_if.sv ***
/*
  Per-lane connection between the top and one deskew FIFO.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/10ps
interface xdr_lane_if;
  logic clr;
  logic wr;
  logic rd;
  logic [8:0] din;
  logic [8:0] dout;
  modport fifo (input clr, input wr, input rd, input din, output dout);
  modport ctrl (output clr, output wr, output rd, output din, input dout);
endinterface

// *** verilog/xdr_dsk_fifo.sv ***
/*
  One lane of the deskew FIFO: plain circular buffer, head shown
  combinationally. Assumes the top never reads it empty.
*/
`timescale 1ns/10ps
module xdr_dsk_fifo
  import xdr_pkg::*;
#(
  parameter int DEPTH = DSK_DEPTH
)
(
  input logic clk,
  input logic rst_n,
  xdr_lane_if.fifo lf
);
  localparam int AW = $clog2(DEPTH);
  logic [8:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic fifo_full;

  assign fifo_full = (wp_r - rp_r) == (AW+1)'(DEPTH);
  assign lf.dout = mem_r[rp_r[AW-1:0]];

  always_comb
  begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (lf.clr)
    begin
      wp_nxt = '0;
      rp_nxt = '0;
    end
    else
    begin
      if (lf.wr && !fifo_full)
        wp_nxt = wp_r + 1'b1;
      if (lf.rd && wp_r != rp_r)
        rp_nxt = rp_r + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (lf.wr && !fifo_full && !lf.clr)
      mem_r[wp_r[AW-1:0]] <= lf.din;
  end

  AST_DSK_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    (wp_r - rp_r) <= (AW+1)'(DEPTH))
    else $error("deskew fifo level out of range");
endmodule // xdr_dsk_fifo

// *** testbench/xdr_far_model.sv ***
/*
  Far transmitter model: drives decoded four-lane columns into the
  receive block. Assumes the bench picks the column kind each cycle.
*/
`timescale 1ns/10ps
module xdr_far_model
  import xdr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] kind,
  input wire logic skew,
  input wire logic [31:0] rnd,
  output logic lane_valid,
  output logic [31:0] lane_data,
  output logic [3:0] lane_kflag
);
  localparam logic [7:0] CODE_SYNC = 8'hbc;
  logic [31:0] col_d;
  logic [3:0] col_k;
  logic [8:0] l3_r = 9'h000;

  always_comb
  begin
    col_k = 4'hf;
    case (kind)
      2'h1: col_d = {4{CODE_ALIGN}};
      2'h2: col_d = {4{CODE_IDLE_R}};
      2'h3:
      begin
        col_d = rnd;
        col_k = 4'h0;
      end
      default: col_d = {4{CODE_SYNC}};
    endcase
  end

  // lane 3 one word late when skewed, as a long trace would make it
  always @(posedge clk)
  begin
    l3_r <= {col_k[3], col_d[31:24]};
    lane_valid <= rst_n;
    lane_data <= col_d;
    lane_kflag <= col_k;
    if (skew)
    begin
      lane_data[31:24] <= l3_r[7:0];
      lane_kflag[3] <= l3_r[8];
    end
    // no stale data while not sending
    if (!rst_n)
      lane_data <= ~col_d;
  end
endmodule // xdr_far_model

// *** testbench/tb_four_lane_deskew_rate_match.sv ***
/*
  Bench for the receive deskew and rate match top: lanes come from the
  far model, registers through bus tasks, data checked against a queue.
  Assumes the package and the far model are compiled before it.
*/
`timescale 1ns/10ps
module tb_four_lane_deskew_rate_match;
  import xdr_pkg::*;
  localparam logic [1:0] K_IDLE = 2'h0;
  localparam logic [1:0] K_A = 2'h1;
  localparam logic [1:0] K_R = 2'h2;
  localparam logic [1:0] K_DATA = 2'h3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic receive_logic_reset = 1'b0;
  logic [3:0] lane_sync_in = 4'h0;
  logic fabric_ready = 1'b1;
  logic [4:0] bus_addr = 5'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [1:0] kind = 2'h0;
  logic skew = 1'b1;
  logic cnt_on = 1'b0;
  logic [31:0] lfsr = 32'h8527;
  logic lane_valid, rx_valid, lanes_aligned, irq;
  logic elastic_full_flag, elastic_empty_flag;
  logic [31:0] lane_data, rx_data, bus_rdata, rd_v;
  logic [3:0] lane_kflag, lane_sync_ok, rx_kflag;
  logic [3:0] column_dropped_pulse, column_added_pulse;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_drop = 0, n_add = 0, n_r_in = 0, n_r_out = 0, full_run = 0, snap;

  initial
    forever #10 clk = ~clk;

  xdr_far_model u_far (.clk(clk), .rst_n(rst_n), .kind(kind), .skew(skew),
    .rnd(lfsr), .lane_valid(lane_valid), .lane_data(lane_data),
    .lane_kflag(lane_kflag));

  xdr_rx_top u_dut (.clk(clk), .rst_n(rst_n),
    .receive_logic_reset(receive_logic_reset), .lane_sync_in(lane_sync_in),
    .lane_valid(lane_valid), .lane_data(lane_data), .lane_kflag(lane_kflag),
    .fabric_ready(fabric_ready), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .lane_sync_ok(lane_sync_ok),
    .lanes_aligned(lanes_aligned), .rx_data(rx_data), .rx_kflag(rx_kflag),
    .rx_valid(rx_valid), .column_dropped_pulse(column_dropped_pulse),
    .column_added_pulse(column_added_pulse),
    .elastic_full_flag(elastic_full_flag),
    .elastic_empty_flag(elastic_empty_flag), .bus_rdata(bus_rdata),
    .irq(irq));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [1:0] k, input int n);
    kind <= k;
    repeat (n) @(posedge clk);
  endtask

  // extra edge so a following write never re-drives the strobe at once
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask

  task automatic acquire();
    int d0;
    d0 = n_drop + n_add;
    for (int g = 0; g < 4; g++)
    begin
      send(K_A, 1);
      send(g < 3 ? K_R : K_IDLE, 7);
      if (g == 2)
      begin
        check("early_align", lanes_aligned, 0);
        check("early_rm", n_drop + n_add, d0);
      end
    end
    send(K_IDLE, 3);
    check("aligned", lanes_aligned, 1);
  endtask

  // stimulus copy of the far model feeds the queue model
  always @(posedge clk)
  begin
    cycles++;
    lfsr <= lfsr_next(lfsr);
    if (cnt_on && kind == K_DATA)
      exp_q.push_back(lfsr);
    if (cnt_on && kind == K_R)
      n_r_in++;
    if (cycles == 5000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  always @(posedge clk)
    if (rst_n)
    begin
      if (column_dropped_pulse != 4'h0)
      begin
        check("drop", column_dropped_pulse, 4'hf);
        n_drop++;
      end
      if (column_added_pulse != 4'h0)
      begin
        check("add", column_added_pulse, 4'hf);
        n_add++;
      end
      if (rx_valid && rx_kflag === 4'h0)
        check("data", rx_data, exp_q.size() ? exp_q.pop_front() : 0);
      if (rx_valid && rx_kflag === 4'hf && rx_data === {4{CODE_IDLE_R}})
        n_r_out++;
      if (elastic_full_flag)
        full_run++;
      else if (full_run != 0)
      begin
        check("full_hold", full_run >= FLAG_HOLD, 1);
        full_run = 0;
      end
    end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("rst_out", {lanes_aligned, lane_sync_ok, rx_valid, irq}, 0);
    bus_read(ADDR_CTRL, rd_v);
    check("ctrl_rst", rd_v, {31'h0, CTRL_RST});
    bus_read(ADDR_IRQ_EN, rd_v);
    check("irq_en_rst", rd_v, 0);
    bus_read(5'h14, rd_v);
    check("unmapped", rd_v, 0);
    lane_sync_in <= 4'hf;
    send(K_IDLE, 3);
    check("sync_ok", lane_sync_ok, 4'hf);
    acquire();
    fabric_ready <= 1'b0;
    send(K_IDLE, 2);
    fabric_ready <= 1'b1;
    send(K_IDLE, 10);
    n_drop = 0;
    n_add = 0;
    n_r_out = 0;
    cnt_on <= 1'b1;
    repeat (6)
    begin
      send(K_DATA, 1);
      send(K_R, 2);
    end
    // stalled fabric: fill climbs to the high mark, then every further idle column is dropped
    fabric_ready <= 1'b0;
    send(K_DATA, 6);
    send(K_R, 30);
    cnt_on <= 1'b0;
    fabric_ready <= 1'b1;
    send(K_IDLE, 30);
    check("r_balance", n_r_out, n_r_in - n_drop + n_add);
    check("adds_seen", n_add > 0, 1);
    check("drops_seen", n_drop > 0, 1);
    check("q_empty", exp_q.size(), 0);
    bus_read(ADDR_STATUS, rd_v);
    check("status", rd_v & 32'hf, 32'h1 << EV_ALIGN_UP | 32'h1 << EV_DROP |
      32'h1 << EV_ADD);
    check("irq_masked", irq, 0);
    bus_write(ADDR_IRQ_EN, 32'h1 << EV_DROP);
    send(K_IDLE, 1);
    check("irq_on", irq, 1);
    bus_write(ADDR_IRQ_CLR, 32'h1 << EV_DROP);
    send(K_IDLE, 1);
    check("irq_off", irq, 0);
    bus_write(ADDR_CTRL, 32'h0);
    bus_read(ADDR_CTRL, rd_v);
    check("ctrl_rw", rd_v, 0);
    snap = n_drop + n_add;
    fabric_ready <= 1'b0;
    send(K_R, 3);
    for (int i = 0; i < 20 && elastic_full_flag !== 1'b1; i++)
      send(K_DATA, 1);
    check("full", elastic_full_flag, 1);
    send(K_DATA, 4);
    check("no_repair", n_drop + n_add, snap);
    bus_read(ADDR_STATE, rd_v);
    check("fill_full", rd_v[ST_FILL_LSB +: 5], EB_DEPTH);
    receive_logic_reset <= 1'b1;
    send(K_IDLE, 1);
    receive_logic_reset <= 1'b0;
    fabric_ready <= 1'b1;
    send(K_IDLE, 2);
    check("rlr", {lanes_aligned, elastic_full_flag, elastic_empty_flag,
      column_dropped_pulse, column_added_pulse}, 0);
    bus_write(ADDR_CTRL, 32'h1);
    acquire();
    lane_sync_in <= 4'hb;
    send(K_IDLE, 3);
    check("sync_loss", lane_sync_ok, 4'hb);
    check("sync_unalign", lanes_aligned, 0);
    lane_sync_in <= 4'hf;
    acquire();
    skew <= 1'b0;
    send(K_A, 1);
    send(K_IDLE, 7);
    check("still_aligned", lanes_aligned, 1);
    repeat (4)
    begin
      send(K_A, 1);
      send(K_IDLE, 7);
    end
    check("align_lost", lanes_aligned, 0);
    give_verdict();
  end
endmodule // tb_four_lane_deskew_rate_match
